// ==== pmt_period_match_timer.sv ====
// Functional notes
// - eight-bit count and period, software read/write
// - timer clocked by oscillator divided by four
// - prescaler ratios 1, 4 or 16
// - count compared against period every clock
// - count wraps to zero after match
// - each match advances postscaler by one
// - postscaler divides matches 1 through 16
// - postscaler output sets match interrupt flag
// - reset loads count 00h, period FFh
// - timer runs only while run enable set
// - control fields select prescale and postscale ratios
// - count or control write, reset clear scalers
// - control write leaves count unchanged
// - flag sets regardless of interrupt enable bits
// - request needs group, own and global enables
`include "pmt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module pmt_period_match_timer (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	// axi4-lite write response
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read address
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	// axi4-lite read data
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// interrupt request towards the core
	output var  logic        irq_request
);
	// ********************************
	// state
	// ********************************
	logic [7:0] tick_count;
	logic [7:0] period_limit;
	logic       run_enable;
	logic [1:0] prescale_select;
	logic [3:0] postscale_select;
	logic       match_irq_flag;
	logic       match_irq_enable;
	logic       peripheral_group_enable;
	logic       global_irq_enable;
	logic [1:0] instr_div;
	logic [3:0] pre_cnt;
	logic [3:0] post_cnt;
	logic       aw_held;
	logic       w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// ********************************
	// helpers
	// ********************************
	function automatic logic [3:0] pre_last(input logic [1:0] sel);
		case (pmt_pkg::pmt_pre_t'(sel))
			pmt_pkg::PMT_PRE_DIV1: pre_last = 4'h0;
			pmt_pkg::PMT_PRE_DIV4: pre_last = 4'h3;
			default:               pre_last = 4'hF;
		endcase
	endfunction : pre_last

	// ********************************
	// bus decode
	// ********************************
	logic do_write;
	logic wr_count;
	logic wr_ctrl;
	logic wr_period;
	logic wr_flags;
	assign do_write  = aw_held && w_held && !s_axi_bvalid;
	assign wr_count  = do_write && aw_addr == `PMT_OFF_TICK_COUNT && w_strb[0];
	assign wr_period = do_write && aw_addr == `PMT_OFF_PERIOD_LIMIT && w_strb[0];
	assign wr_ctrl   = do_write && aw_addr == `PMT_OFF_TIMER_CTRL && w_strb[0];
	assign wr_flags  = do_write && aw_addr == `PMT_OFF_IRQ_FLAGS;

	// ********************************
	// timebase
	// ********************************
	logic instr_tick;
	logic pre_tick;
	logic is_match;
	logic inc_event;
	logic post_out;
	assign instr_tick = instr_div == `PMT_INSTR_DIV;
	assign pre_tick   = instr_tick && pre_cnt == pre_last(prescale_select);
	assign is_match   = tick_count == period_limit;
	assign inc_event  = run_enable && pre_tick && !wr_count && !wr_ctrl;
	assign post_out   = inc_event && is_match && post_cnt == postscale_select;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			instr_div <= 2'h0;
		end else begin
			instr_div <= instr_div + 2'h1;
		end
	end

	// scaler counters: reset, count write or control write clear them
	always_ff @(posedge aclk) begin
		if (!aresetn || wr_count || wr_ctrl) begin
			pre_cnt  <= 4'h0;
			post_cnt <= 4'h0;
		end else begin
			if (run_enable && instr_tick) begin
				pre_cnt <= pre_tick ? 4'h0 : pre_cnt + 4'h1;
			end
			if (inc_event && is_match) begin
				post_cnt <= (post_cnt == postscale_select) ? 4'h0 : post_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick_count <= `PMT_RST_TICK_COUNT;
		end else if (wr_count) begin
			tick_count <= w_data[7:0];
		end else if (inc_event) begin
			tick_count <= is_match ? 8'h00 : tick_count + 8'h01;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			period_limit <= `PMT_RST_PERIOD_LIMIT;
		end else if (wr_period) begin
			period_limit <= w_data[7:0];
		end
	end

	// control write does not touch tick_count
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_enable       <= 1'b0;
			prescale_select  <= 2'h0;
			postscale_select <= 4'h0;
		end else if (wr_ctrl) begin
			run_enable       <= w_data[`PMT_CTRL_RUN_BIT];
			prescale_select  <= w_data[`PMT_CTRL_PRE_LO +: 2];
			postscale_select <= w_data[`PMT_CTRL_POST_LO +: 4];
		end
	end

	// flag: set wins over a software clear in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_irq_flag          <= 1'b0;
			match_irq_enable        <= 1'b0;
			peripheral_group_enable <= 1'b0;
			global_irq_enable       <= 1'b0;
		end else begin
			if (post_out) begin
				match_irq_flag <= 1'b1;
			end else if (wr_flags && w_strb[0]) begin
				match_irq_flag <= match_irq_flag & w_data[`PMT_FLAG_MATCH_BIT];
			end
			if (wr_flags && w_strb[1]) begin
				match_irq_enable        <= w_data[`PMT_ENA_MATCH_BIT];
				peripheral_group_enable <= w_data[`PMT_ENA_GROUP_BIT];
				global_irq_enable       <= w_data[`PMT_ENA_GLOBAL_BIT];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_request <= 1'b0;
		end else begin
			irq_request <= match_irq_flag && match_irq_enable
				&& peripheral_group_enable && global_irq_enable;
		end
	end

	// ********************************
	// axi4-lite slave
	// ********************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 4'h0;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
		end else begin
			s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
			s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= 2'h0;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				case ({s_axi_araddr[3:2], 2'b00})
					`PMT_OFF_TICK_COUNT:   s_axi_rdata <= {24'h00_0000, tick_count};
					`PMT_OFF_PERIOD_LIMIT: s_axi_rdata <= {24'h00_0000, period_limit};
					`PMT_OFF_TIMER_CTRL:   s_axi_rdata <= {25'h000_0000, postscale_select,
						run_enable, prescale_select};
					default: s_axi_rdata <= {21'h00_0000, global_irq_enable,
						peripheral_group_enable, match_irq_enable, 6'h00, match_irq_flag, 1'b0};
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ********************************
	// checks
	// ********************************
	AST_RESET_VALUES: assert property (@(posedge aclk) !aresetn |=>
		tick_count == 8'h00 && period_limit == 8'hFF) else $error("reset values wrong");
	AST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
		inc_event && is_match |=> tick_count == 8'h00) else $error("no wrap at match");
	AST_STOPPED: assert property (@(posedge aclk) disable iff (!aresetn)
		!run_enable && !wr_count |=> $stable(tick_count)) else $error("count moved while off");
	AST_SCALER_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_count || wr_ctrl |=> pre_cnt == 4'h0 && post_cnt == 4'h0)
		else $error("scalers not cleared");
	AST_CTRL_KEEPS_COUNT: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl |=> tick_count == $past(tick_count)) else $error("control write moved count");
	AST_FLAG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
		post_out |=> match_irq_flag) else $error("flag not set");
	AST_FLAG_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
		match_irq_flag && !wr_flags |=> match_irq_flag) else $error("flag cleared itself");
	AST_IRQ_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
		!peripheral_group_enable |=> !irq_request) else $error("irq without group enable");
	AST_PRE_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
		pre_cnt <= pre_last(prescale_select) || $past(wr_ctrl)) else $error("prescaler overrun");
	AST_PRE_ADVANCE: assert property (@(posedge aclk) disable iff (!aresetn)
		run_enable && instr_tick && !pre_tick && !wr_count && !wr_ctrl |=> pre_cnt == $past(pre_cnt) + 4'h1)
		else $error("prescaler did not advance");
	AST_PRE_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
		run_enable && pre_tick && !wr_count && !wr_ctrl |=> pre_cnt == 4'h0)
		else $error("prescaler did not wrap");
	AST_INSTR_TICK: assert property (@(posedge aclk) disable iff (!aresetn)
		instr_tick |=> !instr_tick ##1 !instr_tick ##1 !instr_tick ##1 instr_tick)
		else $error("instruction tick not every fourth clock");
	AST_COUNT_STEP: assert property (@(posedge aclk) disable iff (!aresetn)
		inc_event && !is_match |=> tick_count == $past(tick_count) + 8'h01)
		else $error("count did not step");
	AST_COUNT_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_count |=> tick_count == $past(w_data[7:0]))
		else $error("count write lost");
	AST_PERIOD_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_period |=> period_limit == $past(w_data[7:0]))
		else $error("period write lost");
	AST_PERIOD_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_period |=> $stable(period_limit))
		else $error("period moved without write");
	AST_POST_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		!(inc_event && is_match) && !wr_count && !wr_ctrl |=> $stable(post_cnt))
		else $error("postscaler moved without match");
	AST_POST_BOUND: assert property (@(posedge aclk) disable iff (!aresetn)
		post_cnt <= postscale_select)
		else $error("postscaler overrun");
	AST_POST_WRAP: assert property (@(posedge aclk) disable iff (!aresetn)
		post_out |=> post_cnt == 4'h0)
		else $error("postscaler did not wrap");
	AST_CTRL_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl |=> prescale_select == $past(w_data[`PMT_CTRL_PRE_LO +: 2]))
		else $error("prescale select write lost");
	AST_RUN_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl |=> run_enable == $past(w_data[`PMT_CTRL_RUN_BIT]))
		else $error("run enable write lost");
	AST_FLAG_ONLY_POST: assert property (@(posedge aclk) disable iff (!aresetn)
		!match_irq_flag && !post_out |=> !match_irq_flag)
		else $error("flag set without postscaler output");
	AST_FLAG_NO_ENABLE: assert property (@(posedge aclk) disable iff (!aresetn)
		post_out && !global_irq_enable |=> match_irq_flag)
		else $error("flag waited for enable");
	AST_FLAG_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_flags && w_strb[0] && !w_data[`PMT_FLAG_MATCH_BIT] && !post_out |=> !match_irq_flag)
		else $error("flag clear lost");
	AST_IRQ_RAISE: assert property (@(posedge aclk) disable iff (!aresetn)
		match_irq_flag && match_irq_enable && peripheral_group_enable && global_irq_enable
		|=> irq_request) else $error("irq not raised");
	AST_IRQ_NEEDS_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
		!match_irq_flag |=> !irq_request)
		else $error("irq without flag");
	AST_IRQ_NEEDS_GLOBAL: assert property (@(posedge aclk) disable iff (!aresetn)
		!global_irq_enable |=> !irq_request)
		else $error("irq without global enable");

	// ********************************
	// checks: bus
	// ********************************
	// a response must stand until the master takes it, or data is lost
	AST_BVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	AST_RVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped");
	AST_AWREADY_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_awready |=> !s_axi_awready)
		else $error("address ready held");
endmodule : pmt_period_match_timer
`default_nettype wire

// ==== pmt_map.svh ====
`ifndef PMT_MAP_SVH
`define PMT_MAP_SVH
// ********************************
// register offsets (byte addresses)
// ********************************
`define PMT_OFF_TICK_COUNT   4'h0
`define PMT_OFF_PERIOD_LIMIT 4'h4
`define PMT_OFF_TIMER_CTRL   4'h8
`define PMT_OFF_IRQ_FLAGS    4'hC
// ********************************
// field positions
// ********************************
`define PMT_CTRL_RUN_BIT     2
`define PMT_CTRL_PRE_LO      0
`define PMT_CTRL_POST_LO     3
`define PMT_FLAG_MATCH_BIT   1
`define PMT_ENA_MATCH_BIT    8
`define PMT_ENA_GROUP_BIT    9
`define PMT_ENA_GLOBAL_BIT   10
// ********************************
// reset values and timing
// ********************************
`define PMT_RST_TICK_COUNT   8'h00
`define PMT_RST_PERIOD_LIMIT 8'hFF
`define PMT_INSTR_DIV        2'h3
`endif

// ==== pmt_pkg.sv ====
`default_nettype none
package pmt_pkg;
	typedef enum logic [1:0] {
		PMT_PRE_DIV1,
		PMT_PRE_DIV4,
		PMT_PRE_DIV16,
		PMT_PRE_DIV16B
	} pmt_pre_t;
endpackage : pmt_pkg
`default_nettype wire

// ==== test_period_match_timer.sv ====
`include "pmt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_period_match_timer;
	// ********************************
	// stimulus and design
	// ********************************
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [3:0]  awaddr  = 4'h0;
	logic [3:0]  araddr  = 4'h0;
	logic [3:0]  wstrb   = 4'h0;
	logic [31:0] wdata   = 32'h0000_0000;
	logic        awvalid = 1'b0;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	wire logic   awready, wready, bvalid, arready, rvalid, irq;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          n_errors   = 0;
	int          n_compared = 0;
	int          cyc        = 0;
	always #4 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	pmt_period_match_timer dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_request(irq));
	// ********************************
	// bus cycles and comparisons
	// ********************************
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	task automatic tmo();
		n_errors++;
		summarize();
	endtask : tmo
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
		n_compared++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
		end
	endtask : chk_in
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		int k;
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a; wdata <= d; wstrb <= s;
		awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		for (k = 0; k < 50 && !(aw_ok && w_ok); k++) begin
			@(posedge aclk);
			if (s_ok(awready)) begin aw_ok = 1'b1; awvalid <= 1'b0; end
			if (s_ok(wready)) begin w_ok = 1'b1; wvalid <= 1'b0; end
		end
		if (!(aw_ok && w_ok)) tmo();
		for (k = 0; k < 50 && !s_ok(bvalid); k++) @(posedge aclk);
		if (k == 50) tmo();
		chk(32'(bresp), 32'h0000_0000);
		bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	function automatic bit s_ok(input logic v);
		return v === 1'b1;
	endfunction : s_ok
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		int k;
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		for (k = 0; k < 50 && !s_ok(arready); k++) @(posedge aclk);
		if (k == 50) tmo();
		arvalid <= 1'b0;
		for (k = 0; k < 50 && !s_ok(rvalid); k++) @(posedge aclk);
		if (k == 50) tmo();
		d = rdata;
		chk(32'(rresp), 32'h0000_0000);
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// ********************************
	// scenarios
	// ********************************
	task automatic t_reset_rw();
		logic [31:0] r;
		rd(`PMT_OFF_TICK_COUNT, r);   chk(r, 32'h0000_0000);
		rd(`PMT_OFF_PERIOD_LIMIT, r); chk(r, 32'h0000_00FF);
		rd(`PMT_OFF_IRQ_FLAGS, r);    chk(r, 32'h0000_0000);
		wr(`PMT_OFF_TICK_COUNT, 32'h0000_005A, 4'h1);
		wr(`PMT_OFF_PERIOD_LIMIT, 32'h0000_00A5, 4'h1);
		// a write with the low lane off must leave the register alone
		wr(`PMT_OFF_PERIOD_LIMIT, 32'h0000_0011, 4'h0);
		rd(`PMT_OFF_TICK_COUNT, r);   chk(r, 32'h0000_005A);
		rd(`PMT_OFF_PERIOD_LIMIT, r); chk(r, 32'h0000_00A5);
		$display("test reset_rw done");
	endtask : t_reset_rw
	task automatic t_prescale();
		logic [31:0] r;
		int ex;
		wr(`PMT_OFF_PERIOD_LIMIT, 32'h0000_00FF, 4'h1);
		for (int p = 0; p < 3; p++) begin
			ex = 640 / (4 * (4 ** p));
			wr(`PMT_OFF_TICK_COUNT, 32'h0000_0000, 4'h1);
			wr(`PMT_OFF_TIMER_CTRL, 32'(p) | 32'h0000_0004, 4'h1);
			repeat (640) @(posedge aclk);
			wr(`PMT_OFF_TIMER_CTRL, 32'(p), 4'h1);
			rd(`PMT_OFF_TICK_COUNT, r);
			chk_in(r, ex - 3, ex + 3);
			wr(`PMT_OFF_TIMER_CTRL, 32'h0000_0000, 4'h1);
			rd(`PMT_OFF_TICK_COUNT, r);
			chk_in(r, ex - 3, ex + 3);
		end
		$display("test prescale done");
	endtask : t_prescale
	task automatic t_wrap();
		logic [31:0] r;
		wr(`PMT_OFF_PERIOD_LIMIT, 32'h0000_0003, 4'h1);
		wr(`PMT_OFF_TICK_COUNT, 32'h0000_0000, 4'h1);
		wr(`PMT_OFF_TIMER_CTRL, 32'h0000_0004, 4'h1);
		repeat (12) begin
			rd(`PMT_OFF_TICK_COUNT, r);
			chk_in(r, 0, 3);
		end
		$display("test wrap done");
	endtask : t_wrap
	task automatic t_post(input int n);
		logic [31:0] r;
		int t0;
		wr(`PMT_OFF_TIMER_CTRL, 32'h0000_0000, 4'h1);
		wr(`PMT_OFF_IRQ_FLAGS, 32'h0000_0000, 4'h3);
		// period zero makes every prescaled tick a match
		wr(`PMT_OFF_PERIOD_LIMIT, 32'h0000_0000, 4'h1);
		wr(`PMT_OFF_TICK_COUNT, 32'h0000_0000, 4'h1);
		wr(`PMT_OFF_TIMER_CTRL, (32'(n) << `PMT_CTRL_POST_LO) | 32'h0000_0004, 4'h1);
		t0 = cyc;
		r = 32'h0000_0000;
		for (int k = 0; k < 60 && r[1] !== 1'b1; k++) rd(`PMT_OFF_IRQ_FLAGS, r);
		chk(r & 32'h0000_0002, 32'h0000_0002);
		chk_in(32'(cyc - t0), 4 * n, 4 * (n + 1) + 12);
		rd(`PMT_OFF_TIMER_CTRL, r);
		chk(r, (32'(n) << `PMT_CTRL_POST_LO) | 32'h0000_0004);
		$display("test post %0d done", n);
	endtask : t_post
	task automatic t_irq();
		logic [31:0] r;
		chk(32'(irq), 32'h0000_0000);
		wr(`PMT_OFF_IRQ_FLAGS, 32'h0000_0302, 4'h3);
		repeat (3) @(posedge aclk);
		chk(32'(irq), 32'h0000_0000);
		wr(`PMT_OFF_IRQ_FLAGS, 32'h0000_0702, 4'h3);
		repeat (3) @(posedge aclk);
		chk(32'(irq), 32'h0000_0001);
		wr(`PMT_OFF_TIMER_CTRL, 32'h0000_0000, 4'h1);
		rd(`PMT_OFF_IRQ_FLAGS, r); chk(r, 32'h0000_0702);
		wr(`PMT_OFF_IRQ_FLAGS, 32'h0000_0700, 4'h3);
		repeat (3) @(posedge aclk);
		rd(`PMT_OFF_IRQ_FLAGS, r); chk(r, 32'h0000_0700);
		chk(32'(irq), 32'h0000_0000);
		$display("test irq done");
	endtask : t_irq
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset_rw();
		t_prescale();
		t_wrap();
		t_post(0);
		t_post(15);
		t_irq();
		summarize();
	end
endmodule : test_period_match_timer
`default_nettype wire
